//--- verilog/gpc_pkg.sv
// gpc_pkg: constants, register indices and carrier structs for the
// eight-bit port pin control block.
// assumes: single 200 MHz clock, plain address/strobe register port.
package gpc_pkg;

    localparam int GPC_PINS = 8;
    localparam int GPC_ADDR_W = 4;

    // register indices on the plain register port
    localparam logic [3:0] GPC_REG_FUNC_SEL = 4'h0;
    localparam logic [3:0] GPC_REG_DIRECTION = 4'h1;
    localparam logic [3:0] GPC_REG_INPUT_LEVEL = 4'h2;
    localparam logic [3:0] GPC_REG_OUTPUT_VALUE = 4'h3;
    localparam logic [3:0] GPC_REG_PULLUP_EN = 4'h4;
    localparam logic [3:0] GPC_REG_FAST_SLEW = 4'h5;
    localparam logic [3:0] GPC_REG_ALT_CHOICE = 4'h6;

    // reset values of the cleared registers
    localparam logic [7:0] GPC_RST_ZERO = 8'h00;
    // answer on an unmapped address
    localparam logic [7:0] GPC_UNMAPPED_DATA = 8'h00;

    // register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } gpc_req_s;

    // pad-side controls for the whole port
    typedef struct packed {
        logic [7:0] out_data;
        logic [7:0] out_en;
        logic [7:0] pullup_on;
        logic [7:0] fast_slew;
        logic [7:0] in_buf_en;
    } gpc_pad_s;

    // peripheral side: what the peripherals drive, data and output enable
    typedef struct packed {
        logic [7:0] out_data;
        logic [7:0] out_en;
    } gpc_periph_drive_s;

endpackage

//--- verilog/gpc_port.sv
// gpc_port: one eight-bit port of general-purpose pins with peripheral
// takeover, direction, output value, weak pull-up and slew control.
// assumes: pad inputs are synchronous to clk or settle through the
// two-flop stage here; peripherals live outside and use sel outputs.
`timescale 1ns/1ps

module gpc_port
    import gpc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] pad_in,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe,
    output logic [7:0] pad_pullup,
    output logic [7:0] pad_fast_slew,
    output logic [7:0] pad_in_buf_en,
    input wire logic [7:0] periph_a_out,
    input wire logic [7:0] periph_a_oe,
    input wire logic [7:0] periph_b_out,
    input wire logic [7:0] periph_b_oe,
    output logic [7:0] periph_a_sel,
    output logic [7:0] periph_b_sel,
    output logic [7:0] periph_in
);

    ////////////////////////////////////////////////////////////////////
    // request bundle and address decode

    gpc_req_s req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr,
                   rd: reg_rd};

    wire logic hit_func = req.addr == GPC_REG_FUNC_SEL;
    wire logic hit_dir = req.addr == GPC_REG_DIRECTION;
    wire logic hit_in = req.addr == GPC_REG_INPUT_LEVEL;
    wire logic hit_out = req.addr == GPC_REG_OUTPUT_VALUE;
    wire logic hit_pu = req.addr == GPC_REG_PULLUP_EN;
    wire logic hit_slew = req.addr == GPC_REG_FAST_SLEW;
    wire logic hit_alt = req.addr == GPC_REG_ALT_CHOICE;

    // write enables; input level has none since it is read-only
    wire logic wr_func = req.wr && hit_func;
    wire logic wr_dir = req.wr && hit_dir;
    wire logic wr_out = req.wr && hit_out;
    wire logic wr_pu = req.wr && hit_pu;
    wire logic wr_slew = req.wr && hit_slew;
    wire logic wr_alt = req.wr && hit_alt;

    ////////////////////////////////////////////////////////////////////
    // control registers

    logic [7:0] pin_function_select;
    logic [7:0] pin_direction;
    logic [7:0] pin_output_value;
    logic [7:0] pin_pullup_enable;
    logic [7:0] pin_fast_slew;
    logic [7:0] pin_alternate_choice;
    logic [7:0] pin_input_level;

    // registers that reset clears
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_function_select <= GPC_RST_ZERO;
            pin_direction <= GPC_RST_ZERO;
            pin_pullup_enable <= GPC_RST_ZERO;
            pin_fast_slew <= GPC_RST_ZERO;
            pin_alternate_choice <= GPC_RST_ZERO;
        end else begin
            if (wr_func) pin_function_select <= req.wdata;
            if (wr_dir) pin_direction <= req.wdata;
            if (wr_pu) pin_pullup_enable <= req.wdata;
            if (wr_slew) pin_fast_slew <= req.wdata;
            if (wr_alt) pin_alternate_choice <= req.wdata;
        end
    end

    // output value: no reset, unknown until first write
    always_ff @(posedge clk) begin
        if (wr_out) pin_output_value <= req.wdata;
    end

    ////////////////////////////////////////////////////////////////////
    // input synchroniser; first stage feeds only the second

    logic [7:0] sync_meta;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync_meta <= GPC_RST_ZERO;
            pin_input_level <= GPC_RST_ZERO;
        end else begin
            sync_meta <= pad_in;
            pin_input_level <= sync_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // per-pin output, pull-up, slew and peripheral muxing

    logic [7:0] next_pad_out;
    logic [7:0] next_pad_oe;
    logic [7:0] next_pad_pullup;
    logic [7:0] next_pad_in_buf_en;
    logic [7:0] next_sel_a;
    logic [7:0] next_sel_b;

    // general input buffer opens while software reads input level
    wire logic reading_in = req.rd && hit_in;

    genvar i;
    generate
        for (i = 0; i < GPC_PINS; i++) begin : g_pin
            wire logic alt = pin_function_select[i];
            wire logic choice = pin_alternate_choice[i];
            // choice only counts when the pin is handed over
            wire logic use_b = alt && choice;
            wire logic p_out = use_b ? periph_b_out[i] : periph_a_out[i];
            wire logic p_oe = use_b ? periph_b_oe[i] : periph_a_oe[i];
            // general mode: value bit and direction; open drain by
            // holding value 0 and toggling direction
            wire logic g_out = pin_output_value[i];
            wire logic g_oe = pin_direction[i];
            assign next_pad_out[i] = alt ? p_out : g_out;
            assign next_pad_oe[i] = alt ? p_oe : g_oe;
            // pull-up: general mode with buffer off, never in alternate
            assign next_pad_pullup[i] = !alt && !g_oe
                                        && pin_pullup_enable[i];
            assign next_pad_in_buf_en[i] = alt || reading_in;
            assign next_sel_a[i] = alt && !choice;
            assign next_sel_b[i] = use_b;
        end
    endgenerate

    // pad controls; drive stays combinational so writes act at once
    gpc_pad_s pad;
    assign pad = '{out_data: next_pad_out, out_en: next_pad_oe,
                   pullup_on: next_pad_pullup, fast_slew: pin_fast_slew,
                   in_buf_en: next_pad_in_buf_en};
    assign pad_out = pad.out_data;
    assign pad_oe = pad.out_en;
    assign pad_pullup = pad.pullup_on;
    assign pad_fast_slew = pad.fast_slew;
    assign pad_in_buf_en = pad.in_buf_en;
    assign periph_a_sel = next_sel_a;
    assign periph_b_sel = next_sel_b;
    assign periph_in = pin_input_level;

    ////////////////////////////////////////////////////////////////////
    // read-back mux, data registered one cycle after the strobe

    logic [7:0] rd_mux;
    always_comb begin
        case (req.addr)
            GPC_REG_FUNC_SEL: rd_mux = pin_function_select;
            GPC_REG_DIRECTION: rd_mux = pin_direction;
            GPC_REG_INPUT_LEVEL: rd_mux = pin_input_level;
            GPC_REG_OUTPUT_VALUE: rd_mux = pin_output_value;
            GPC_REG_PULLUP_EN: rd_mux = pin_pullup_enable;
            GPC_REG_FAST_SLEW: rd_mux = pin_fast_slew;
            GPC_REG_ALT_CHOICE: rd_mux = pin_alternate_choice;
            default: rd_mux = GPC_UNMAPPED_DATA;
        endcase
    end

    // read data holds only in the cycle after the read strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= GPC_RST_ZERO;
        end else begin
            reg_rdata <= req.rd ? rd_mux : GPC_RST_ZERO;
        end
    end

endmodule

//--- test/gpc_port_asserts.sv
// gpc_port_asserts: port-level checks of the pin control block.
// assumes: bound to gpc_port, one clock, async active-low reset.
`timescale 1ns/1ps
module gpc_port_asserts
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] pad_in,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pad_pullup,
    input wire logic [7:0] pad_in_buf_en,
    input wire logic [7:0] periph_a_oe,
    input wire logic [7:0] periph_b_out,
    input wire logic [7:0] periph_a_sel,
    input wire logic [7:0] periph_b_sel,
    input wire logic [7:0] periph_in
);
    // pins handed over, input level reads, edges since release
    wire [7:0] alt = periph_a_sel | periph_b_sel;
    wire din_rd = reg_rd && reg_addr == 4'h2;
    logic [1:0] age;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) age <= 2'h0;
        else if (!age[1]) age <= age + 2'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_dir_wr;
        reg_wr && reg_addr == 4'h1;
    endsequence
    a_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not idle");
    a_alt_oe: assert property (((pad_oe ^ periph_a_oe) & periph_a_sel) == 0)
        else $error("alt enable wrong");
    a_alt_out: assert property (((pad_out ^ periph_b_out) & periph_b_sel) == 0)
        else $error("alt data wrong");
    a_alt_pull_off: assert property ((pad_pullup & alt) == 8'h00)
        else $error("pull-up in alt mode");
    a_pull_drive: assert property ((pad_pullup & pad_oe) == 8'h00)
        else $error("pull-up while driving");
    a_sync_two: assert property (age[1] |-> periph_in == $past(pad_in, 2))
        else $error("sync latency wrong");
    a_inbuf_en: assert property (pad_in_buf_en == (din_rd ? 8'hFF : alt))
        else $error("input buffer enable wrong");
    a_dir_write: assert property (s_dir_wr |=> ((pad_oe ^ $past(reg_wdata)) & ~alt) == 0)
        else $error("direction not applied");
endmodule
bind gpc_port gpc_port_asserts u_gpc_port_asserts(.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
    .pad_in_buf_en(pad_in_buf_en), .periph_a_oe(periph_a_oe),
    .periph_b_out(periph_b_out), .periph_a_sel(periph_a_sel),
    .periph_b_sel(periph_b_sel), .periph_in(periph_in));

//--- test/gpc_periph_model.sv
// gpc_periph_model: pins and peripherals outside the port block.
// assumes: peripherals drive only pins handed to them.
`timescale 1ns/1ps
module gpc_periph_model
(
    input wire logic clk,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pad_pullup,
    input wire logic [7:0] ext_drv,
    input wire logic [7:0] ext_lvl,
    input wire logic [7:0] sel_a,
    input wire logic [7:0] sel_b,
    output logic [7:0] pad_in,
    output logic [7:0] a_out,
    output logic [7:0] a_oe,
    output logic [7:0] b_out,
    output logic [7:0] b_oe
);
    logic [7:0] churn = 8'h00;
    // changing pattern on floating lines
    always @(posedge clk) churn <= churn + 8'h01;
    // pin: port buffer, outside driver, pull-up, else floating
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drv & ext_lvl)
        | (~pad_oe & ~ext_drv & (pad_pullup | churn));
    // peripherals enable drive only on pins already handed over
    assign a_out = sel_a ? 8'h5A : churn;
    assign a_oe = sel_a & 8'h0F;
    assign b_out = sel_b ? 8'hC3 : ~churn;
    assign b_oe = sel_b & 8'hF0;
endmodule

//--- test/testbench.sv
// testbench: register and pin checks of the port control block.
// assumes: gpc_port, its checker and the pin/peripheral model.
`timescale 1ns/1ps
module testbench;
    import gpc_pkg::*;
    typedef struct packed {logic [3:0] a; logic [7:0] d, e;} gpc_row_s;
    logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdat = 8'h00, ext_drv = 8'h03, ext_lvl = 8'h01;
    wire [7:0] rdat, pin, po, oe, pu, slew, ibuf, ao, ae, bo, be, as, bs;
    wire [7:0] pi;
    int num_errors = 0, checks_done = 0;
    gpc_row_s rows [8] = '{'{4'h1, 8'h3C, 8'h3C}, '{4'h3, 8'h96, 8'h96},
        '{4'h4, 8'hF0, 8'hF0}, '{4'h2, 8'h00, 8'hD5}, '{4'h5, 8'h81, 8'h81},
        '{4'h6, 8'h55, 8'h55}, '{4'h0, 8'h00, 8'h00}, '{4'hF, 8'hAA, 8'h00}};
    always #2.5 clk = ~clk;
    gpc_port u_gpc_port(.clk(clk), .resetn(resetn), .reg_addr(addr),
        .reg_wdata(wdat), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
        .pad_in(pin), .pad_out(po), .pad_oe(oe), .pad_pullup(pu),
        .pad_fast_slew(slew), .pad_in_buf_en(ibuf), .periph_a_out(ao),
        .periph_a_oe(ae), .periph_b_out(bo), .periph_b_oe(be),
        .periph_a_sel(as), .periph_b_sel(bs), .periph_in(pi));
    gpc_periph_model u_gpc_periph_model(.clk(clk), .pad_out(po),
        .pad_oe(oe), .pad_pullup(pu), .ext_drv(ext_drv), .ext_lvl(ext_lvl),
        .sel_a(as), .sel_b(bs), .pad_in(pin), .a_out(ao), .a_oe(ae),
        .b_out(bo), .b_oe(be));
    ////////////////////////////////////////////////////////////////////
    // comparison, bus cycles, reset
    task automatic chk(input string n, input logic [7:0] e, g);
        checks_done++;
        if (g !== e) begin
            $display("[FAIL] %s exp %h got %h", n, e, g);
            num_errors++;
        end
    endtask
    task automatic wrt(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("reg_rdata", e, rdat);
    endtask
    task automatic do_rst;
        @(posedge clk);
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 7; i++) if (i != 2 && i != 3) rdc(i[3:0], 8'h00);
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        #20000;
        num_errors++;
        stop_test;
    end
    // main sequence
    initial begin
        do_rst;
        chk("pad_oe", 8'h00, oe);
        foreach (rows[i]) begin
            wrt(rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].e);
        end
        chk("pad_oe", 8'h3C, oe);
        chk("periph_in", 8'hD5, pi);
        chk("pad_out", 8'h14, po & 8'h3C);
        chk("pad_pullup", 8'hC0, pu);
        chk("periph_a_sel", 8'h00, as);
        wrt(4'h0, 8'hFF);
        chk("periph_b_sel", 8'h55, bs);
        chk("pad_oe", 8'h5A, oe);
        chk("pad_out", 8'h4B, po);
        chk("pad_pullup", 8'h00, pu);
        chk("pad_in_buf_en", 8'hFF, ibuf);
        chk("pad_fast_slew", 8'h81, slew);
        // open-drain use: value zero, direction toggled
        wrt(4'h0, 8'h00);
        wrt(4'h6, 8'h00);
        wrt(4'h3, 8'h00);
        wrt(4'h4, 8'h01);
        wrt(4'h1, 8'h01);
        chk("pad_oe", 8'h01, oe);
        chk("pad_out", 8'h00, po);
        wrt(4'h1, 8'h00);
        chk("pad_pullup", 8'h01, pu);
        do_rst;
        rdc(4'h3, 8'h00);
        stop_test;
    end
endmodule
